/* rtl/adcrw_pkg.sv */
// Constants and types for the converter result and window register block
// Operation
// - One 8-bit byte latch, readable and writable, is shared by all 16-bit registers here.
// - The result is a read-only 16-bit value, low byte at its base, high byte one above.
// - A single conversion yields a 10-bit code in result bits 9 down to 0.
// - A conversion saturates to 0x3FF above the reference and to 0x000 below zero volts.
// - At most 64 conversions are accumulated, so the sum never passes 0xFFC0.
// - Values are plain unsigned, 0x0000 is zero and 0x3FF full scale for one conversion.
// - A 16-bit read/write low threshold, reset to zero, feeds the window comparator.
// - The low threshold has its low byte at its base and its high byte one above.
// - A 16-bit read/write high threshold, reset to zero, feeds the window comparator.
// - The high threshold has its low byte at its base and its high byte one above.
// - While accumulating, only the final accumulated value is compared.
// - The duty select bit resets to 1 for a 25% high clock, 50% at divide-by-2; 0 gives 50%.
// - Reading the result low byte clears both flags; writing 1 to a flag clears it, 0 does nothing.
// - Window modes: 0 none, 1 below low, 2 above high, 3 strictly inside, 4 outside.
// - The window match flag sets at the end of a conversion that meets the mode.
package adcrw_pkg;

	typedef logic [4:0] adcrw_addr_t;

	localparam adcrw_addr_t OFS_WIN_MODE = 5'h04;
	localparam adcrw_addr_t OFS_FLAGS = 5'h0B;
	localparam adcrw_addr_t OFS_LATCH = 5'h0D;
	localparam adcrw_addr_t OFS_RES_LO = 5'h10;
	localparam adcrw_addr_t OFS_RES_HI = 5'h11;
	localparam adcrw_addr_t OFS_WINDOW_LOW_THRESHOLD_LO = 5'h12;
	localparam adcrw_addr_t OFS_WINDOW_LOW_THRESHOLD_HI = 5'h13;
	localparam adcrw_addr_t OFS_WINDOW_HIGH_THRESHOLD_LO = 5'h14;
	localparam adcrw_addr_t OFS_WINDOW_HIGH_THRESHOLD_HI = 5'h15;
	localparam adcrw_addr_t OFS_CONVERTER_CLOCK_CALIBRATION = 5'h16;

	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [15:0] RES_RST = 16'h0000;
	localparam logic [15:0] WIN_RST = 16'h0000;
	localparam logic DUTY_RST = 1'h1;
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [7:0] RDATA_RST = 8'h00;

	localparam int unsigned DUTY_BIT = 0;
	localparam int unsigned FLAG_READY_BIT = 0;
	localparam int unsigned FLAG_WIN_BIT = 1;

	localparam logic [9:0] SAT_HIGH = 10'h3FF;
	localparam logic [9:0] SAT_LOW = 10'h000;
	localparam logic [2:0] ACC_MAX_LOG2 = 3'h6;
	localparam logic [6:0] ACC_CNT_RST = 7'h00;

	localparam logic [8:0] DIV_BASE = 9'h002;
	localparam logic [7:0] DIV_CNT_RST = 8'h00;

	typedef enum logic [2:0] {
		WIN_NONE = 3'b000,
		WIN_BELOW = 3'b001,
		WIN_ABOVE = 3'b010,
		WIN_INSIDE = 3'b011,
		WIN_OUTSIDE = 3'b100
	} adcrw_win_mode_t;

	typedef struct packed {
		logic wr;
		logic rd;
		adcrw_addr_t addr;
		logic [7:0] wdata;
	} adcrw_bus_req_t;

	typedef struct packed {
		logic valid;
		logic over;
		logic under;
		logic [9:0] code;
	} adcrw_sample_t;

endpackage

/* rtl/adcrw_clkgen.sv */
// Converter clock divider with selectable duty cycle
`timescale 1ns/10ps
`default_nettype none
module adcrw_clkgen (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic [2:0] presc_sel_in,
	input wire logic duty_quarter_in,
	output logic adc_clk_out,
	output logic adc_tick_out
);
	logic [8:0] period;
	logic [7:0] last_cnt;
	logic [8:0] high_len;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;

	always_comb begin
		period = 9'(adcrw_pkg::DIV_BASE << presc_sel_in);
		last_cnt = 8'(period - 9'h001);
		// 25% high when the duty bit is set, 50% otherwise
		// Duty cycle select
		if (duty_quarter_in) begin
			high_len = period >> 2;
		end else begin
			high_len = period >> 1;
		end
		// Divide-by-2 cannot give a quarter; keep at least one high cycle
		if (high_len == 9'h000) begin
			high_len = 9'h001;
		end
		if (cnt_q >= last_cnt) begin
			cnt_d = adcrw_pkg::DIV_CNT_RST;
		end else begin
			cnt_d = cnt_q + 8'h01;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_q <= adcrw_pkg::DIV_CNT_RST;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			adc_clk_out <= 1'b0;
			adc_tick_out <= 1'b0;
		end else begin
			adc_clk_out <= ({1'b0, cnt_d} < high_len);
			adc_tick_out <= (cnt_d == adcrw_pkg::DIV_CNT_RST);
		end
	end
endmodule
`default_nettype wire

/* rtl/adcrw_regs.sv */
// Result, window threshold and calibration registers of the converter
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module adcrw_regs (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire adcrw_pkg::adcrw_bus_req_t bus_req_in,
	output logic [7:0] rd_data_out,
	input wire logic [2:0] presc_sel_in,
	input wire logic [2:0] accum_log2_in,
	input wire adcrw_pkg::adcrw_sample_t conv_sample_in,
	output logic adc_clk_out,
	output logic adc_tick_out,
	output logic result_ready_out,
	output logic window_match_out,
	output logic accum_busy_out
);
	logic [7:0] latch_q;
	logic [15:0] result_q;
	logic [15:0] win_low_q;
	logic [15:0] win_high_q;
	logic duty_q;
	logic [2:0] mode_q;
	logic ready_flag_q;
	logic win_flag_q;
	logic [15:0] acc_sum_q;
	logic [6:0] acc_cnt_q;
	logic [7:0] rdata_q;

	logic wr_en;
	logic rd_en;
	adcrw_pkg::adcrw_addr_t addr;
	logic [7:0] wdata;

	logic [9:0] sat_code;
	logic [2:0] acc_log2;
	logic [6:0] acc_target;
	logic [15:0] sum_next;
	logic [6:0] cnt_next;
	logic conv_done;
	logic below_low;
	logic above_high;
	logic win_hit;
	logic res_read;
	logic ready_clr;
	logic win_clr;
	logic [7:0] rd_mux;
	logic wr_latch;
	logic wr_lt_lo;
	logic wr_lt_hi;
	logic wr_ht_lo;
	logic wr_ht_hi;
	logic wr_converter_clock_calibration;
	logic wr_mode;
	logic wr_flags;

	assign wr_en = bus_req_in.wr;
	assign rd_en = bus_req_in.rd;
	assign addr = bus_req_in.addr;
	assign wdata = bus_req_in.wdata;

	// One write strobe per address; the latch block also takes both threshold low-byte strobes
	always_comb begin
		wr_latch = 1'b0;
		wr_lt_lo = 1'b0;
		wr_lt_hi = 1'b0;
		wr_ht_lo = 1'b0;
		wr_ht_hi = 1'b0;
		wr_converter_clock_calibration = 1'b0;
		wr_mode = 1'b0;
		wr_flags = 1'b0;
		if (wr_en) begin
			if (addr == adcrw_pkg::OFS_LATCH) begin
				wr_latch = 1'b1;
			end else if (addr == adcrw_pkg::OFS_WINDOW_LOW_THRESHOLD_LO) begin
				wr_lt_lo = 1'b1;
			end else if (addr == adcrw_pkg::OFS_WINDOW_LOW_THRESHOLD_HI) begin
				wr_lt_hi = 1'b1;
			end else if (addr == adcrw_pkg::OFS_WINDOW_HIGH_THRESHOLD_LO) begin
				wr_ht_lo = 1'b1;
			end else if (addr == adcrw_pkg::OFS_WINDOW_HIGH_THRESHOLD_HI) begin
				wr_ht_hi = 1'b1;
			end else if (addr == adcrw_pkg::OFS_CONVERTER_CLOCK_CALIBRATION) begin
				wr_converter_clock_calibration = 1'b1;
			end else if (addr == adcrw_pkg::OFS_WIN_MODE) begin
				wr_mode = 1'b1;
			end else if (addr == adcrw_pkg::OFS_FLAGS) begin
				wr_flags = 1'b1;
			end
		end
	end

	adcrw_clkgen u_clkgen (
		.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in),
		.presc_sel_in(presc_sel_in),
		.duty_quarter_in(duty_q),
		.adc_clk_out(adc_clk_out),
		.adc_tick_out(adc_tick_out)
	);

	// Sample conditioning and accumulation
	always_comb begin
		if (conv_sample_in.over) begin
			sat_code = adcrw_pkg::SAT_HIGH;
		end else if (conv_sample_in.under) begin
			sat_code = adcrw_pkg::SAT_LOW;
		end else begin
			sat_code = conv_sample_in.code;
		end
		if (accum_log2_in > adcrw_pkg::ACC_MAX_LOG2) begin
			acc_log2 = adcrw_pkg::ACC_MAX_LOG2;
		end else begin
			acc_log2 = accum_log2_in;
		end
		acc_target = 7'(7'h01 << acc_log2);
		// Code in bits 9 down to 0
		sum_next = acc_sum_q + {6'h00, sat_code};
		cnt_next = acc_cnt_q + 7'h01;
		conv_done = conv_sample_in.valid && (cnt_next >= acc_target);
	end

	// Sum of at most 64 codes of 0x3FF is 0xFFC0, so 16 bits never wrap
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			acc_sum_q <= adcrw_pkg::RES_RST;
			acc_cnt_q <= adcrw_pkg::ACC_CNT_RST;
		end else if (conv_done) begin
			acc_sum_q <= adcrw_pkg::RES_RST;
			acc_cnt_q <= adcrw_pkg::ACC_CNT_RST;
		end else if (conv_sample_in.valid) begin
			acc_sum_q <= sum_next;
			acc_cnt_q <= cnt_next;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			result_q <= adcrw_pkg::RES_RST;
		end else if (conv_done) begin
			result_q <= sum_next;
		end
	end

	// Window comparison on the completed value
	always_comb begin
		below_low = (sum_next < win_low_q);
		above_high = (sum_next > win_high_q);
		case (mode_q)
			adcrw_pkg::WIN_BELOW: begin
				win_hit = below_low;
			end
			adcrw_pkg::WIN_ABOVE: begin
				win_hit = above_high;
			end
			adcrw_pkg::WIN_INSIDE: begin
				win_hit = (sum_next > win_low_q) && (sum_next < win_high_q);
			end
			adcrw_pkg::WIN_OUTSIDE: begin
				win_hit = below_low || above_high;
			end
			default: begin
				// No comparison and reserved codes never match
				win_hit = 1'b0;
			end
		endcase
	end

	// Flag clearing terms
	always_comb begin
		res_read = rd_en && (addr == adcrw_pkg::OFS_RES_LO);
		ready_clr = res_read;
		win_clr = res_read;
		if (wr_flags) begin
			ready_clr = ready_clr || wdata[adcrw_pkg::FLAG_READY_BIT];
			win_clr = win_clr || wdata[adcrw_pkg::FLAG_WIN_BIT];
		end
	end

	// A completion in the same cycle as a clear wins, so no result is missed
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ready_flag_q <= 1'b0;
		end else if (conv_done) begin
			ready_flag_q <= 1'b1;
		end else if (ready_clr) begin
			ready_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			win_flag_q <= 1'b0;
		end else if (conv_done && win_hit) begin
			win_flag_q <= 1'b1;
		end else if (win_clr) begin
			win_flag_q <= 1'b0;
		end
	end

	// Shared byte latch
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			latch_q <= adcrw_pkg::LATCH_RST;
		end else if (wr_latch) begin
			latch_q <= wdata;
		end else if (wr_lt_lo || wr_ht_lo) begin
			latch_q <= wdata;
		end else if (rd_en) begin
			if (addr == adcrw_pkg::OFS_RES_LO) begin
				latch_q <= result_q[15:8];
			end else if (addr == adcrw_pkg::OFS_WINDOW_LOW_THRESHOLD_LO) begin
				latch_q <= win_low_q[15:8];
			end else if (addr == adcrw_pkg::OFS_WINDOW_HIGH_THRESHOLD_LO) begin
				latch_q <= win_high_q[15:8];
			end
		end
	end

	// Thresholds commit as a whole word on the high-byte write
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			win_low_q <= adcrw_pkg::WIN_RST;
		end else if (wr_lt_hi) begin
			win_low_q <= {wdata, latch_q};
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			win_high_q <= adcrw_pkg::WIN_RST;
		end else if (wr_ht_hi) begin
			win_high_q <= {wdata, latch_q};
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			duty_q <= adcrw_pkg::DUTY_RST;
		end else if (wr_converter_clock_calibration) begin
			duty_q <= wdata[adcrw_pkg::DUTY_BIT];
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mode_q <= adcrw_pkg::MODE_RST;
		end else if (wr_mode) begin
			mode_q <= wdata[2:0];
		end
	end

	// Read multiplexer
	always_comb begin
		rd_mux = adcrw_pkg::RDATA_RST;
		if (addr == adcrw_pkg::OFS_WIN_MODE) begin
			rd_mux = {5'h00, mode_q};
		end else if (addr == adcrw_pkg::OFS_FLAGS) begin
			rd_mux = {6'h00, win_flag_q, ready_flag_q};
		end else if (addr == adcrw_pkg::OFS_LATCH) begin
			rd_mux = latch_q;
		end else if (addr == adcrw_pkg::OFS_RES_LO) begin
			rd_mux = result_q[7:0];
		end else if (addr == adcrw_pkg::OFS_WINDOW_LOW_THRESHOLD_LO) begin
			rd_mux = win_low_q[7:0];
		end else if (addr == adcrw_pkg::OFS_WINDOW_HIGH_THRESHOLD_LO) begin
			rd_mux = win_high_q[7:0];
		end else if (addr == adcrw_pkg::OFS_RES_HI) begin
			rd_mux = latch_q;
		end else if (addr == adcrw_pkg::OFS_WINDOW_LOW_THRESHOLD_HI) begin
			rd_mux = latch_q;
		end else if (addr == adcrw_pkg::OFS_WINDOW_HIGH_THRESHOLD_HI) begin
			rd_mux = latch_q;
		end else if (addr == adcrw_pkg::OFS_CONVERTER_CLOCK_CALIBRATION) begin
			rd_mux = {7'h00, duty_q};
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_q <= adcrw_pkg::RDATA_RST;
		end else if (rd_en) begin
			rdata_q <= rd_mux;
		end else begin
			rdata_q <= adcrw_pkg::RDATA_RST;
		end
	end

	assign rd_data_out = rdata_q;
	assign result_ready_out = ready_flag_q;
	assign window_match_out = win_flag_q;
	assign accum_busy_out = (acc_cnt_q != adcrw_pkg::ACC_CNT_RST);
endmodule
`default_nettype wire

/* tb/adcrw_conv_model.sv */
// Converter sample source standing in for the analog core
`timescale 1ns/10ps
`default_nettype none
module adcrw_conv_model (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic req_in,
	input wire logic [11:0] smp_in,
	output var adcrw_pkg::adcrw_sample_t sample_out
);
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sample_out <= '0;
		end else if (req_in) begin
			sample_out <= {1'b1, smp_in};
		end else begin
			// Stale code is inverted so it never looks like a fresh sample
			sample_out <= {3'b000, ~sample_out.code};
		end
	end
endmodule
`default_nettype wire

/* tb/adcrw_regs_assertions.sv */
// Port-level checker for the converter result and window registers
`timescale 1ns/10ps
`default_nettype none
module adcrw_checker (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire adcrw_pkg::adcrw_bus_req_t bus_req_in,
	input wire logic [7:0] rd_data_out,
	input wire logic [2:0] presc_sel_in,
	input wire logic [2:0] accum_log2_in,
	input wire adcrw_pkg::adcrw_sample_t conv_sample_in,
	input wire logic adc_clk_out,
	input wire logic adc_tick_out,
	input wire logic result_ready_out,
	input wire logic window_match_out,
	input wire logic accum_busy_out
);
	logic duty_q;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	// Shadow of the duty bit, only the bus can change it
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			duty_q <= 1'b1;
		end else if (bus_req_in.wr && bus_req_in.addr == 5'h16) begin
			duty_q <= bus_req_in.wdata[0];
		end
	end
	rd_idle_a: assert property (!bus_req_in.rd |=> rd_data_out == 8'h00)
		else $error("read data not idle");
	latch_rw_a: assert property (bus_req_in.wr && bus_req_in.addr == 5'h0D ##1
		bus_req_in.rd && bus_req_in.addr == 5'h0D |=> rd_data_out == $past(bus_req_in.wdata, 2))
		else $error("latch readback wrong");
	flag_rdclr_a: assert property (bus_req_in.rd && bus_req_in.addr == 5'h10
		&& !conv_sample_in.valid |=> !result_ready_out && !window_match_out)
		else $error("flags not cleared by result read");
	flag_w1c_a: assert property (bus_req_in.wr && bus_req_in.addr == 5'h0B
		&& bus_req_in.wdata[0] && !conv_sample_in.valid |=> !result_ready_out)
		else $error("ready flag not cleared by one");
	flag_w0_a: assert property (result_ready_out && bus_req_in.wr
		&& bus_req_in.addr == 5'h0B && !bus_req_in.wdata[0] |=> result_ready_out)
		else $error("ready flag lost on zero write");
	win_w1c_a: assert property (bus_req_in.wr && bus_req_in.addr == 5'h0B
		&& bus_req_in.wdata[1] && !conv_sample_in.valid |=> !window_match_out)
		else $error("window flag not cleared by one");
	ready_hold_a: assert property (result_ready_out && !(bus_req_in.rd
		&& bus_req_in.addr == 5'h10) && !(bus_req_in.wr && bus_req_in.addr == 5'h0B)
		|=> result_ready_out)
		else $error("ready flag dropped without a clear");
	sat_high_a: assert property (conv_sample_in.valid && conv_sample_in.over
		&& accum_log2_in == 3'h0 && !accum_busy_out ##[1:4]
		bus_req_in.rd && bus_req_in.addr == 5'h10 |=> rd_data_out == 8'hFF)
		else $error("over-range not saturated");
	ready_set_a: assert property (conv_sample_in.valid && accum_log2_in == 3'h0
		|=> result_ready_out)
		else $error("ready flag missing after conversion");
	win_with_ready_a: assert property ($rose(window_match_out) |-> result_ready_out)
		else $error("window flag set without a result");
	acc_busy_a: assert property (conv_sample_in.valid && accum_log2_in == 3'h2
		&& !accum_busy_out |=> accum_busy_out)
		else $error("partial sum not held");
	tick_rise_a: assert property ($rose(adc_clk_out) |-> adc_tick_out)
		else $error("tick not at clock rise");
	duty_a: assert property (adc_tick_out && presc_sel_in == 3'h1
		|=> adc_clk_out == !duty_q)
		else $error("converter clock duty wrong");
endmodule
bind adcrw_regs adcrw_checker i_chk (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
	.bus_req_in(bus_req_in), .rd_data_out(rd_data_out), .presc_sel_in(presc_sel_in),
	.accum_log2_in(accum_log2_in), .conv_sample_in(conv_sample_in), .adc_clk_out(adc_clk_out),
	.adc_tick_out(adc_tick_out), .result_ready_out(result_ready_out),
	.window_match_out(window_match_out), .accum_busy_out(accum_busy_out));
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the converter result and window registers
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic sys_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	adcrw_pkg::adcrw_bus_req_t bus = '0;
	logic [7:0] rdata;
	logic [2:0] acc_log2 = 3'h0;
	logic req = 1'b0;
	logic [11:0] smp = 12'h000;
	adcrw_pkg::adcrw_sample_t sample;
	logic rd_q = 1'b0;
	logic [7:0] exp_q[$];
	logic [4:0] ra[11] = '{5'h0D, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h04,
		5'h0B, 5'h1F};
	int n_mismatch = 0;
	int checked = 0;
	logic [15:0] lt, ht, v, sum;
	logic [9:0] c;
	logic m;
	initial begin
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	adcrw_conv_model i_model (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .req_in(req),
		.smp_in(smp), .sample_out(sample));
	// Prescale fixed at divide-by-4 so the two duty settings differ
	adcrw_regs i_dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .bus_req_in(bus),
		.rd_data_out(rdata), .presc_sel_in(3'h1), .accum_log2_in(acc_log2),
		.conv_sample_in(sample), .adc_clk_out(), .adc_tick_out(), .result_ready_out(),
		.window_match_out(), .accum_busy_out());
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checked++;
		if (seen !== want) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic complete_run();
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Strobe stays up until the next call; reads note their expected byte
	task automatic op(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		bus <= {w, !w, a, d};
		if (!w) begin
			exp_q.push_back(d);
		end
	endtask
	task automatic wr16(input logic [4:0] a, input logic [15:0] d);
		op(1'b1, a, d[7:0]);
		op(1'b1, a + 5'h01, d[15:8]);
	endtask
	task automatic rd16(input logic [4:0] a, input logic [15:0] d);
		op(1'b0, a, d[7:0]);
		op(1'b0, a + 5'h01, d[15:8]);
	endtask
	task automatic sample_once(input logic [11:0] s);
		@(posedge sys_clk_in);
		bus <= '0;
		req <= 1'b1;
		smp <= s;
		@(posedge sys_clk_in);
		req <= 1'b0;
	endtask
	always @(posedge sys_clk_in) begin
		if (rd_q) begin
			check(rdata, exp_q.pop_front());
		end
		rd_q <= bus.rd;
	end
	initial begin
		#100_000;
		n_mismatch++;
		complete_run();
	end
	initial begin
		void'($urandom(67222));
		repeat (2) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		op(1'b1, 5'h10, 8'hAA);
		foreach (ra[i]) op(1'b0, ra[i], {7'h00, ra[i] == 5'h16});
		op(1'b1, 5'h16, 8'h00);
		op(1'b0, 5'h16, 8'h00);
		c = 10'($urandom);
		op(1'b1, 5'h0D, c[7:0]);
		op(1'b0, 5'h0D, c[7:0]);
		lt = 16'h0100 | 16'($urandom_range(0, 127));
		ht = 16'h0300 | 16'($urandom_range(0, 127));
		wr16(5'h12, lt);
		wr16(5'h14, ht);
		rd16(5'h12, lt);
		rd16(5'h14, ht);
		for (int md = 0; md < 6; md++) begin
			op(1'b1, 5'h04, 8'(md));
			for (int k = 0; k < 3; k++) begin
				v = (k == 0) ? 16'h0000 : (k == 1) ? 16'h0200 : 16'h03FF;
				m = (md == 1 && v < lt) || (md == 2 && v > ht) || (md == 3 && v > lt && v < ht)
					|| (md == 4 && (v < lt || v > ht));
				sample_once({k == 2, k == 0, 10'h200});
				op(1'b1, 5'h0B, 8'h00);
				op(1'b0, 5'h0B, {6'h00, m, 1'b1});
				rd16(5'h10, v);
				op(1'b0, 5'h0B, 8'h00);
			end
		end
		op(1'b1, 5'h04, 8'h02);
		for (int r = 0; r < 2; r++) begin
			acc_log2 <= r ? 3'h2 : 3'h7;
			sum = 16'h0000;
			op(1'b1, 5'h0B, 8'h03);
			for (int i = 0; i < (r ? 4 : 64); i++) begin
				c = r ? 10'($urandom) : 10'h3FF;
				sum = sum + 16'(c);
				if (i == (r ? 3 : 63)) begin
					op(1'b0, 5'h0B, 8'h00);
				end
				sample_once({!r[0], 1'b0, r ? c : 10'($urandom)});
			end
			op(1'b0, 5'h0B, {6'h00, sum > ht, 1'b1});
			op(1'b1, 5'h0B, 8'h03);
			op(1'b0, 5'h0B, 8'h00);
			rd16(5'h10, sum);
		end
		sample_once(12'h000);
		repeat (4) @(posedge sys_clk_in);
		complete_run();
	end
endmodule
`default_nettype wire
